//--- hdl/sfphl_pins.v
// Pin front end of a serial flash: sampling, pause, one, two and four lane output.
// Assumes mclk runs well above the serial clock; pins are oversampled.
// Contract
// - Output bits change on falling serial clock
// - Dual read drives lanes one and zero
// - Quad read uses protect and pause pins
// - Protect pin level locks protected regions
// - Pause keeps selection and command state
// - Paused: ignore clock, data; output tri-stated
// - Self-timed cycles run on while paused
// - Floating protect pin reads as deasserted
// - Floating pause pin reads as inactive
// - Select edges frame operations; deselected tri-states
// - Input bits captured on rising serial clock
`timescale 1ns/100ps
`default_nettype none
`include "sfphl_regs.vh"
module sfphl_pins (
  input  wire                      mclk,
  input  wire                      rstn,
  input  wire                      cs_n,
  input  wire                      sck,
  input  wire                      lane_zero_in,
  input  wire                      lane_one_in,
  input  wire                      lane_two_in,
  input  wire                      lane_three_in,
  output reg                       lane_zero_out,
  output reg                       lane_one_out,
  output reg                       lane_two_out,
  output reg                       lane_three_out,
  output wire                      lane_zero_oe_n,
  output wire                      lane_one_oe_n,
  output wire                      lane_two_oe_n,
  output wire                      lane_three_oe_n,
  input  wire [`SFPHL_MODE_W-1:0]  out_mode,
  input  wire                      out_enable,
  input  wire [`SFPHL_BYTE_W-1:0]  tx_byte,
  output wire                      tx_take,
  output reg  [`SFPHL_BYTE_W-1:0]  rx_byte,
  output reg                       rx_valid,
  output wire                      op_start,
  output wire                      op_end,
  output reg                       selected,
  output wire                      paused,
  output wire                      write_protect_n
);
  // Three-stage samplers per pin; change counts when stages two and three agree
  localparam NPIN = 6;
  // Pull-ups idle select and lanes high; the clock idles low, so no false edge
  localparam [NPIN-1:0] PIN_IDLE = 6'h3D;
  wire [NPIN-1:0] raw = {lane_three_in, lane_two_in, lane_one_in, lane_zero_in, sck, cs_n};
  reg  [NPIN-1:0] s1;
  reg  [NPIN-1:0] s2;
  reg  [NPIN-1:0] s3;
  reg  [NPIN-1:0] filt;
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      // Floating protect and pause pins read inactive through their pull-ups
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          s1[g]   <= PIN_IDLE[g];
          s2[g]   <= PIN_IDLE[g];
          s3[g]   <= PIN_IDLE[g];
          filt[g] <= PIN_IDLE[g];
        end else begin
          s1[g] <= raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            filt[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  wire cs_f  = filt[0];
  wire sck_f = filt[1];
  reg  cs_d;
  reg  sck_d;
  reg  pause_act;
  reg  [`SFPHL_BITCNT_W-1:0] in_cnt;
  reg  [`SFPHL_BYTE_W-1:0]   in_sh;
  reg  [`SFPHL_BYTE_W-1:0]   out_sh;
  reg  [`SFPHL_BITCNT_W-1:0] out_cnt;
  reg  out_loaded;

  // Quad mode owns the pause pin, so pausing is only possible outside it
  wire quad_on  = out_enable && (out_mode == `SFPHL_MODE_QUAD);
  wire dual_on  = out_enable && (out_mode == `SFPHL_MODE_DUAL);
  wire hold_pin = filt[5];
  wire sck_rise = sck_f && !sck_d && !pause_act && selected;
  wire sck_fall = !sck_f && sck_d && !pause_act && selected;
  assign op_start = cs_d && !cs_f;
  assign op_end   = !cs_d && cs_f;
  assign paused   = pause_act;
  // Protect level only meaningful while the pin is not a data lane
  assign write_protect_n = quad_on ? 1'b1 : filt[4];
  // No link to program or erase timers: pause gates only this block's receive and transmit shifters and drivers

  wire [`SFPHL_BITCNT_W-1:0] step =
    quad_on ? 3'h4 : (dual_on ? 3'h2 : 3'h1);
  wire [`SFPHL_BITCNT_W-1:0] next_out_cnt = out_cnt + step;

  // tx_take and the shifter agree on when a fresh byte is due
  wire load_now = !out_loaded || (out_cnt == 3'h0);
  wire [`SFPHL_BYTE_W-1:0] out_src = load_now ? tx_byte : out_sh;

  // Select tracking from filtered chip select edges
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_d     <= 1'b1;
      selected <= 1'b0;
    end else begin
      cs_d <= cs_f;
      if (op_start) begin
        selected <= 1'b1;
      end else if (op_end) begin
        selected <= 1'b0;
      end
    end
  end

  // Clock edge memory frozen while paused so resume sees no false edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_d <= 1'b0;
    end else if (!pause_act) begin
      sck_d <= sck_f;
    end
  end

  // Deselect beats a pause request landing in the same cycle
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pause_act <= 1'b0;
    end else if (op_end) begin
      pause_act <= 1'b0;
    end else if (selected && !quad_on && !pause_act && !hold_pin && !sck_f) begin
      pause_act <= 1'b1;
    end else if (pause_act && hold_pin && !sck_f) begin
      pause_act <= 1'b0;
    end
  end

  // Receive shifter, MSB first on lane zero
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      in_cnt   <= 3'h0;
      in_sh    <= 8'h00;
      rx_byte  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (op_start) begin
        in_cnt <= 3'h0;
      end else if (sck_rise && !out_enable) begin
        in_sh  <= {in_sh[6:0], filt[2]};
        in_cnt <= in_cnt + 3'h1;
        if (in_cnt == 3'h7) begin
          rx_byte  <= {in_sh[6:0], filt[2]};
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // Transmit shifter; a new byte is taken when the lane count wraps
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_sh     <= 8'h00;
      out_cnt    <= 3'h0;
      out_loaded <= 1'b0;
    end else if (op_start) begin
      out_cnt    <= 3'h0;
      out_loaded <= 1'b0;
    end else if (sck_fall && out_enable) begin
      out_loaded <= 1'b1;
      out_cnt    <= next_out_cnt;
      if (quad_on) begin
        out_sh <= {out_src[3:0], 4'h0};
      end else if (dual_on) begin
        out_sh <= {out_src[5:0], 2'h0};
      end else begin
        out_sh <= {out_src[6:0], 1'b0};
      end
    end
  end

  // Lane pins follow the shifter source on the same falling edge, MSB first
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lane_zero_out  <= 1'b0;
      lane_one_out   <= 1'b0;
      lane_two_out   <= 1'b0;
      lane_three_out <= 1'b0;
    end else if (sck_fall && out_enable) begin
      if (quad_on) begin
        {lane_three_out, lane_two_out, lane_one_out, lane_zero_out} <= out_src[7:4];
      end else if (dual_on) begin
        {lane_one_out, lane_zero_out} <= out_src[7:6];
      end else begin
        lane_one_out <= out_src[7];
      end
    end
  end

  // Combinational so the byte source can change right after the take
  assign tx_take = sck_fall && out_enable && load_now;
  // Drivers off unless selected, unpaused and outputting
  wire drive = selected && !pause_act && out_enable;
  assign lane_one_oe_n   = !drive;
  assign lane_zero_oe_n  = !(drive && (dual_on || quad_on));
  assign lane_two_oe_n   = !(drive && quad_on);
  assign lane_three_oe_n = !(drive && quad_on);
endmodule
`default_nettype wire

//--- pkg/sfphl_regs.vh
// Constants for the serial flash pin, pause and lane block.
// Assumes inclusion by the pin front end, its checker and its bench; definitions only.
`ifndef SFPHL_REGS_VH
`define SFPHL_REGS_VH
// Lane modes selected by the command decoder
`define SFPHL_MODE_W      2
`define SFPHL_MODE_SINGLE 2'h0
`define SFPHL_MODE_DUAL   2'h1
`define SFPHL_MODE_QUAD   2'h2
// Output byte and sync depth
`define SFPHL_BYTE_W      8
`define SFPHL_BITCNT_W    3
`define SFPHL_SYNC_W      3
`endif

//--- bench/sfphl_host.sv
// Host model: drives select, clock, data and pause pins.
// Assumes callers enter its tasks 1 ns after an mclk edge.
`timescale 1ns/100ps
`default_nettype none
module sfphl_host (
  input  wire logic       mclk,
  input  wire logic [3:0] lanes,
  output var  logic       cs_n = 1'h1,
  output var  logic       sck = 1'h0,
  output var  logic       mosi = 1'h1,
  output var  logic       pause_n = 1'h1
);
  // Half period of eight mclk, above the filter need
  task automatic h;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task automatic sel(input logic v);
    cs_n = v;
    h;
  endtask
  // Pause at bit p; a clock pulse inside it must be ignored
  task automatic cyc(input logic [7:0] d, input int n, w, p, output logic [7:0] q);
    q = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (i == p) begin
        pause_n = 1'h0;
        h;
        sck = 1'h1;
        mosi = ~mosi;
        h;
        sck = 1'h0;
        h;
        pause_n = 1'h1;
      end
      mosi = d[7];
      d = d << 1;
      h;
      q = w == 1 ? {q[6:0], lanes[1]} : w == 2 ? {q[5:0], lanes[1:0]} : {q[3:0], lanes};
      sck = 1'h1;
      h;
      sck = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/sfphl_pins_checker.sv
// Port checker for the pin front end.
// Assumes binding to sfphl_pins; one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "sfphl_regs.vh"
module sfphl_pins_checker (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       lane_two_in,
  input wire logic       lane_three_in,
  input wire logic       lane_zero_oe_n,
  input wire logic       lane_one_oe_n,
  input wire logic       lane_three_oe_n,
  input wire logic       lane_one_out,
  input wire logic [1:0] out_mode,
  input wire logic       out_enable,
  input wire logic       op_start,
  input wire logic       selected,
  input wire logic       paused,
  input wire logic       write_protect_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  desel_tri_a: assert property (cs_n [*8] |-> lane_one_oe_n && lane_zero_oe_n)
    else $error("output driven while deselected");
  pause_tri_a: assert property (paused |-> lane_one_oe_n && lane_zero_oe_n)
    else $error("output driven while paused");
  pause_sel_a: assert property (paused |-> selected)
    else $error("pause lost selection");
  sel_start_a: assert property ($fell(cs_n) |-> ##[2:6] op_start)
    else $error("no start after select");
  out_fall_a: assert property ($rose(sck) |=> $stable(lane_one_out) [*6])
    else $error("output moved after rising clock");
  quad_wp_a: assert property ((out_enable && out_mode == `SFPHL_MODE_QUAD) [*3]
    |-> write_protect_n)
    else $error("protect active in quad");
  wp_lock_a: assert property ((out_mode == `SFPHL_MODE_SINGLE && !lane_two_in) [*8]
    |-> !write_protect_n)
    else $error("protect pin not followed");
  quad_lane_a: assert property (!lane_three_oe_n |-> out_mode == `SFPHL_MODE_QUAD)
    else $error("lane three driven outside quad");
  dual_lane_a: assert property (!lane_zero_oe_n |-> out_mode != `SFPHL_MODE_SINGLE)
    else $error("lane zero driven in single");
  pause_idle_a: assert property (lane_three_in [*8] |-> !paused)
    else $error("pause without low pin");
endmodule
bind sfphl_pins sfphl_pins_checker i_chk (.mclk, .rstn, .cs_n, .sck, .lane_two_in,
  .lane_three_in, .lane_zero_oe_n, .lane_one_oe_n, .lane_three_oe_n, .lane_one_out,
  .out_mode, .out_enable, .op_start, .selected, .paused, .write_protect_n);
`default_nettype wire

//--- bench/sfphl_pins_tb.sv
// Bench for the pin front end: receive, pause, read lanes, protect.
// Assumes a 25 MHz mclk; inputs move 1 ns after its rising edge.
`timescale 1ns/100ps
`default_nettype none
`include "sfphl_regs.vh"
module sfphl_pins_tb;
  // Protect pin high models its pull-up
  logic mclk = 1'h0, rstn = 1'h0, lane_one_in = 1'h1, lane_two_in = 1'h1;
  logic out_enable = 1'h0;
  logic [1:0] out_mode = `SFPHL_MODE_SINGLE;
  logic [7:0] tx_byte = 8'h00, q;
  wire logic [7:0] rx_byte;
  wire logic [3:0] l, e;
  wire logic cs_n, sck, mosi, pause_n, op_start, selected, paused, write_protect_n;
  wire logic rx_valid, op_end, tx_take;
  int bad_count = 0, checked = 0;
  int n_rx = 0, n_end = 0, n_take = 0;
  sfphl_pins i_sfphl_pins (.mclk, .rstn, .cs_n, .sck, .lane_zero_in(mosi), .lane_one_in,
    .lane_two_in, .lane_three_in(pause_n), .lane_zero_out(l[0]), .lane_one_out(l[1]),
    .lane_two_out(l[2]), .lane_three_out(l[3]), .lane_zero_oe_n(e[0]), .lane_one_oe_n(e[1]),
    .lane_two_oe_n(e[2]), .lane_three_oe_n(e[3]), .out_mode, .out_enable, .tx_byte,
    .tx_take, .rx_byte, .rx_valid, .op_start, .op_end, .selected, .paused,
    .write_protect_n);
  // Released lanes show the inverse of their last value
  sfphl_host i_sfphl_host (.mclk, .lanes(l ^ e), .cs_n, .sck, .mosi, .pause_n);
  initial forever #20 mclk = ~mclk;
  // Pulse counters for the one-cycle strobes
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) n_rx++;
    if (op_end === 1'b1) n_end++;
    if (tx_take === 1'b1) n_take++;
  end
  task automatic chk(input string s, input logic [7:0] x, y);
    checked++;
    if (x !== y) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic test_done;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_rx(input int p, input logic [7:0] d);
    n_rx = 0;
    n_end = 0;
    i_sfphl_host.sel(1'h0);
    i_sfphl_host.cyc(d, 8, 1, p, q);
    chk("rx_byte", d, rx_byte);
    chk("rx_valid", 8'h01, n_rx[7:0]);
    chk("selected", 8'h01, {7'h0, selected});
    i_sfphl_host.sel(1'h1);
    chk("op_end", 8'h01, n_end[7:0]);
  endtask
  task automatic t_rd(input logic [1:0] m, input int w, n);
    tx_byte = 8'hC6;
    out_mode = m;
    n_take = 0;
    i_sfphl_host.sel(1'h0);
    out_enable = 1'h1;
    i_sfphl_host.cyc(8'h00, n, w, 99, q);
    chk("read byte", 8'hC6, q);
    i_sfphl_host.sel(1'h1);
    out_enable = 1'h0;
    chk("oe_n", 8'h0F, {4'h0, e});
    chk("tx_take", 8'h02, n_take[7:0]);
  endtask
  task automatic t_wp;
    out_mode = `SFPHL_MODE_SINGLE;
    lane_two_in = 1'h0;
    i_sfphl_host.h;
    chk("write_protect_n", 8'h00, {7'h0, write_protect_n});
    out_mode = `SFPHL_MODE_QUAD;
    out_enable = 1'h1;
    i_sfphl_host.h;
    chk("write_protect_n", 8'h01, {7'h0, write_protect_n});
    out_enable = 1'h0;
    out_mode = `SFPHL_MODE_SINGLE;
    lane_two_in = 1'h1;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    #1;
    chk("oe_n", 8'h0F, {4'h0, e});
    rstn = 1'h1;
    i_sfphl_host.h;
    t_rx(99, 8'hA5);
    t_rx(3, 8'h3C);
    t_rd(`SFPHL_MODE_SINGLE, 1, 9);
    t_rd(`SFPHL_MODE_DUAL, 2, 5);
    t_rd(`SFPHL_MODE_QUAD, 4, 3);
    t_wp;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
